// File: src/adc_range_scan_ctrl.v
/*
  Range and scan control for a multichannel converter front end:
  per-channel range codes, manual / auto-scan multiplexer pointer,
  reference source handling, APB register slave.
  Assumes an APB master on sys_clk; cs_n and reference_source_select
  come from pins and are synchronised here.
*/
// The implementer's own choices: the address map and the APB interface to the registers.
// Summary of operation
// - Each channel keeps own 4-bit range code
// - Range codes reset to bipolar 2.5 span
// - Bipolar codes 0,1,2,3,B decode to spans
// - Unipolar codes 5,6,7,F decode; others undefined
// - Manual mode converts latest selected channel
// - Auto-scan advances pointer on chip-select fall
// - Scan visits enabled channels ascending, skips others
// - Aggregate conversion rate at most 500 kSPS
// - Select low: drive internal reference out
// - Select high: reference pin input, buffered
`timescale 1ns/100ps
`include "range_scan_map.vh"

module adc_range_scan_ctrl #(
  parameter num_channels = 8,
  parameter chan_bits = 3
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cs_n,
  input wire reference_source_select,
  output reg [chan_bits-1:0] mux_channel,
  output reg [3:0] active_range_code,
  output reg range_unipolar,
  output reg range_valid,
  output reg conv_start,
  output reg reference_inout_pin_oe,
  output reg internal_buffer_enable
);

  // ==========================================
  // Pin synchronisers
  // Only the later flops feed logic: cs_sync and cs_prev for cs, reference_source_select_sync for select
  reg cs_meta;
  reg cs_sync;
  reg cs_prev;
  reg reference_source_select_meta;
  reg reference_source_select_sync;

  always @(posedge sys_clk) begin
    if (rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // Reference select is a strap: level only, no edge detect
  always @(posedge sys_clk) begin
    if (rst) begin
      reference_source_select_meta <= 1'b0;
      reference_source_select_sync <= 1'b0;
    end else begin
      reference_source_select_meta <= reference_source_select;
      reference_source_select_sync <= reference_source_select_meta;
    end
  end

  // Idle-high reset values avoid a false fall after reset
  wire cs_fall = cs_prev & ~cs_sync;

  // ==========================================
  // Registers
  reg auto_mode;
  reg [chan_bits-1:0] manual_channel_select;
  reg [num_channels-1:0] scan_enable;
  reg [3:0] channel_range_code [0:num_channels-1];
  reg [15:0] rate_count;

  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire range_hit = (paddr >= `REG_RANGE_BASE) &&
    (paddr < `REG_RANGE_BASE + 12'h004 * num_channels) && (paddr[1:0] == 2'b00);
  wire [chan_bits-1:0] range_idx = paddr[chan_bits+1:2];
  wire rate_ok = (rate_count == 16'h0000);

  genvar gi;
  generate
    for (gi = 0; gi < num_channels; gi = gi + 1) begin : g_range
      always @(posedge sys_clk) begin
        if (rst)
          channel_range_code[gi] <= `RANGE_RESET;
        else if (apb_wr && range_hit && range_idx == gi)
          channel_range_code[gi] <= pwdata[3:0];
      end
    end
  endgenerate

  // Next enabled channel above the pointer, wrapping to the lowest
  reg [chan_bits-1:0] next_scan_channel;
  reg found;
  integer k;
  integer idx;
  always @* begin
    next_scan_channel = mux_channel;
    found = 1'b0;
    idx = 0;
    for (k = 1; k <= num_channels; k = k + 1) begin
      idx = (mux_channel + k) % num_channels;
      if (!found && scan_enable[idx]) begin
        next_scan_channel = idx[chan_bits-1:0];
        found = 1'b1;
      end
    end
  end

  // Decode range code into validity and polarity
  reg next_valid;
  reg next_unipolar;
  always @* begin
    next_valid = 1'b1;
    next_unipolar = 1'b0;
    case (channel_range_code[mux_channel])
      `RANGE_BI_2P5: begin
        next_unipolar = 1'b0;
      end
      `RANGE_BI_1P25: begin
        next_unipolar = 1'b0;
      end
      `RANGE_BI_0P625: begin
        next_unipolar = 1'b0;
      end
      `RANGE_BI_0P3125: begin
        next_unipolar = 1'b0;
      end
      `RANGE_BI_0P15625: begin
        next_unipolar = 1'b0;
      end
      `RANGE_UNI_2P5: begin
        next_unipolar = 1'b1;
      end
      `RANGE_UNI_1P25: begin
        next_unipolar = 1'b1;
      end
      `RANGE_UNI_0P625: begin
        next_unipolar = 1'b1;
      end
      `RANGE_UNI_0P3125: begin
        next_unipolar = 1'b1;
      end
      default: begin
        next_valid = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Write decode
  wire wr_ctrl = apb_wr && (paddr == `REG_CTRL);
  wire wr_manual = apb_wr && (paddr == `REG_MANUAL_SEL);
  wire wr_scan = apb_wr && (paddr == `REG_SCAN_ENABLE);
  wire write_conv = apb_wr && (paddr == `REG_CONV_CMD);

  // ==========================================
  // Mode and selection registers
  always @(posedge sys_clk) begin
    if (rst) begin
      auto_mode <= 1'b0;
      manual_channel_select <= {chan_bits{1'b0}};
      scan_enable <= {num_channels{1'b1}};
    end else begin
      if (wr_ctrl) begin
        auto_mode <= pwdata[`CTRL_AUTO_BIT];
      end
      if (wr_manual) begin
        manual_channel_select <= pwdata[chan_bits-1:0];
      end
      if (wr_scan) begin
        scan_enable <= pwdata[num_channels-1:0];
      end
    end
  end

  // ==========================================
  // Rate limiter
  // Requests inside the period are dropped silently, not queued
  wire start_req = (cs_fall || write_conv) && rate_ok;

  always @(posedge sys_clk) begin
    if (rst) begin
      rate_count <= 16'h0000;
    end else if (start_req) begin
      rate_count <= `CONV_PERIOD_CYCLES - 16'h0001;
    end else if (!rate_ok) begin
      rate_count <= rate_count - 16'h0001;
    end
  end

  // ==========================================
  // Conversion start and range latch
  // Range latched only at start; later writes wait for the next one
  always @(posedge sys_clk) begin
    if (rst) begin
      active_range_code <= `RANGE_RESET;
      range_unipolar <= 1'b0;
      range_valid <= 1'b1;
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_req;
      if (start_req) begin
        active_range_code <= channel_range_code[mux_channel];
        range_unipolar <= next_unipolar;
        range_valid <= next_valid;
      end
    end
  end

  // ==========================================
  // Channel pointer
  // In auto mode the pointer rests on an enabled channel, if any is enabled; a start samples
  // it and then steps on to the next enabled channel, so a channel is sampled twice in a row only when it is the only one enabled or none is
  always @(posedge sys_clk) begin
    if (rst) begin
      mux_channel <= {chan_bits{1'b0}};
    end else if (!auto_mode) begin
      mux_channel <= manual_channel_select;
    end else if (start_req) begin
      mux_channel <= next_scan_channel;
    end else if (!scan_enable[mux_channel]) begin
      mux_channel <= next_scan_channel;
    end
  end

  // ==========================================
  // Reference source
  always @(posedge sys_clk) begin
    if (rst) begin
      reference_inout_pin_oe <= 1'b0;
      internal_buffer_enable <= 1'b0;
    end else begin
      reference_inout_pin_oe <= ~reference_source_select_sync;
      internal_buffer_enable <= reference_source_select_sync;
    end
  end

  // ==========================================
  // Register read mux
  reg [31:0] next_rdata;
  reg next_err;
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (range_hit) begin
      next_rdata[3:0] = channel_range_code[range_idx];
    end else begin
      case (paddr)
        `REG_CTRL: begin
          next_rdata[`CTRL_AUTO_BIT] = auto_mode;
        end
        `REG_MANUAL_SEL: begin
          next_rdata[chan_bits-1:0] = manual_channel_select;
        end
        `REG_SCAN_ENABLE: begin
          next_rdata[num_channels-1:0] = scan_enable;
        end
        `REG_STATUS: begin
          next_rdata[chan_bits-1:0] = mux_channel;
          next_rdata[chan_bits+3:chan_bits] = active_range_code;
          next_rdata[chan_bits+4] = range_unipolar;
          next_rdata[chan_bits+5] = range_valid;
          next_rdata[chan_bits+6] = reference_source_select_sync;
        end
        `REG_CONV_CMD: begin
          next_rdata = 32'h00000000;
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // APB slave, zero wait states
  // Answer registered at the setup edge, so it stands in the access cycle
  wire apb_setup = psel & ~penable;

  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & next_err;
      if (apb_setup & ~pwrite) begin
        prdata <= next_rdata;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // adc_range_scan_ctrl

// File: src/range_scan_map.vh
/*
  Register offsets, field positions, reset values and timing counts for the
  range and scan control block. Included by the design file; no logic here.
*/
`ifndef RANGE_SCAN_MAP_VH
`define RANGE_SCAN_MAP_VH

// ==========================================
// Register byte offsets
`define REG_CTRL 12'h000
`define REG_MANUAL_SEL 12'h004
`define REG_SCAN_ENABLE 12'h008
`define REG_STATUS 12'h00C
`define REG_CONV_CMD 12'h010
`define REG_RANGE_BASE 12'h020

// ==========================================
// Control fields
`define CTRL_AUTO_BIT 0

// ==========================================
// Range codes
`define RANGE_RESET 4'h0
`define RANGE_BI_2P5 4'h0
`define RANGE_BI_1P25 4'h1
`define RANGE_BI_0P625 4'h2
`define RANGE_BI_0P3125 4'h3
`define RANGE_BI_0P15625 4'hB
`define RANGE_UNI_2P5 4'h5
`define RANGE_UNI_1P25 4'h6
`define RANGE_UNI_0P625 4'h7
`define RANGE_UNI_0P3125 4'hF

// ==========================================
// Timing: aggregate rate ceiling and clock rate
`define MAX_RATE_KSPS 500
`define CLK_MHZ 250
// Cycles per start: 250 MHz over 500 kSPS, sized for the rate counter
`define CONV_PERIOD_CYCLES 16'h01F4

`endif

// File: testbench/host_link.sv
/* Host link model: drops chip select for one eight-cycle frame per request.
   Assumes frame_req is a one-cycle pulse on sys_clk. */
`timescale 1ns/100ps
module host_link (
  input wire sys_clk,
  input wire frame_req,
  output reg cs_n = 1'b1
);
  integer left = 0;
  // Idle high between frames so no stray fall is seen
  always @(posedge sys_clk) begin
    if (left != 0)
      left <= left - 1;
    else if (frame_req)
      left <= 8;
    cs_n <= (left == 0 && !frame_req) || left == 1;
  end
endmodule // host_link

// File: testbench/range_scan_monitor.sv
/* Checker on range and scan control ports.
   Assumes one clock domain and a synchronous active-high rst. */
`timescale 1ns/100ps
module range_scan_monitor (
  input wire sys_clk,
  input wire rst,
  input wire conv_start,
  input wire [3:0] active_range_code,
  input wire range_unipolar,
  input wire range_valid,
  input wire reference_source_select,
  input wire reference_inout_pin_oe,
  input wire internal_buffer_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire bip = active_range_code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hB};
  wire uni = active_range_code inside {4'h5, 4'h6, 4'h7, 4'hF};
  property p_reset; disable iff (1'b0) rst |=> active_range_code == 4'h0; endproperty
  a_reset: assert property (p_reset) else $error("range not cleared");
  property p_bipolar; bip |-> range_valid && !range_unipolar; endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar decode");
  property p_unipolar; uni |-> range_valid && range_unipolar; endproperty
  a_unipolar: assert property (p_unipolar) else $error("unipolar decode");
  property p_undefined; !(bip || uni) |-> !range_valid; endproperty
  a_undefined: assert property (p_undefined) else $error("undefined code valid");
  property p_hold; !conv_start |-> $stable(active_range_code); endproperty
  a_hold: assert property (p_hold) else $error("range changed between starts");
  property p_spacing; conv_start |=> !conv_start [*8]; endproperty
  a_spacing: assert property (p_spacing) else $error("starts too close");
  property p_internal; !reference_source_select [*5] |-> reference_inout_pin_oe && !internal_buffer_enable; endproperty
  a_internal: assert property (p_internal) else $error("internal ref not driven");
  property p_external; reference_source_select [*5] |-> internal_buffer_enable && !reference_inout_pin_oe; endproperty
  a_external: assert property (p_external) else $error("external ref not buffered");
  c_unipolar: cover property (conv_start && range_unipolar);
  c_undefined: cover property (conv_start && !range_valid);
  c_external: cover property ($rose(internal_buffer_enable));
endmodule // range_scan_monitor
bind adc_range_scan_ctrl range_scan_monitor range_scan_monitor_inst (.sys_clk, .rst, .conv_start, .active_range_code,
  .range_unipolar, .range_valid, .reference_source_select, .reference_inout_pin_oe, .internal_buffer_enable);

// File: testbench/tb_adc_range_scan_ctrl.sv
/* Self-checking bench: APB host, link model, range and scan model.
   Assumes the register map header is on the include path. */
`timescale 1ns/100ps
`include "range_scan_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_adc_range_scan_ctrl;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, reference_source_select = 0, frame_req = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire pready, pslverr, cs_n, conv_start, range_unipolar, range_valid, reference_inout_pin_oe, internal_buffer_enable;
  wire [2:0] mux_channel;
  wire [3:0] active_range_code;
  integer err_count = 0, checked = 0, seed = 32'hacbb, i, k, p;
  logic [3:0] model_range [8];
  logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hB, 4'h5, 4'h6, 4'h7, 4'hF, 4'h4};
  logic [7:0] mask;
  always #2 sys_clk = ~sys_clk;
  host_link host_link_inst (.sys_clk, .frame_req, .cs_n);
  adc_range_scan_ctrl adc_range_scan_ctrl_inst (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cs_n, .reference_source_select, .mux_channel, .active_range_code, .range_unipolar,
    .range_valid, .conv_start, .reference_inout_pin_oe, .internal_buffer_enable);
  function automatic [2:0] nxt(input [2:0] c, input [7:0] m);
    nxt = c;
    for (int j = 8; j > 0; j--)
      if (m[(c + j) % 8])
        nxt = 3'((c + j) % 8);
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Waits out the 500-cycle spacing so the next request is accepted
  task conv;
    integer n;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (conv_start !== 1'b1 && n < 40);
    `CHK("start", 1'b1, conv_start)
    repeat (510) @(posedge sys_clk);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      apb(0, 12'(`REG_RANGE_BASE + 4 * i), 0);
      `CHK("range reset", 32'h0, q)
      model_range[i] = codes[$unsigned($random(seed)) % 9];
      apb(1, 12'(`REG_RANGE_BASE + 4 * i), {28'h0, model_range[i]});
    end
    for (i = 0; i < 8; i++) begin
      apb(0, 12'(`REG_RANGE_BASE + 4 * i), 0);
      `CHK("range rd", {28'h0, model_range[i]}, q)
    end
    apb(0, 12'h0FC, 0);
    `CHK("unmapped", 1'b1, e)
    for (k = 0; k < 10; k++) begin
      apb(1, `REG_MANUAL_SEL, k % 8);
      apb(1, 12'(`REG_RANGE_BASE + 4 * (k % 8)), {28'h0, codes[k]});
      apb(1, `REG_CONV_CMD, 1);
      conv;
      `CHK("man ch", 3'(k % 8), mux_channel)
      `CHK("code", codes[k], active_range_code)
      `CHK("valid", codes[k] != 4'h4, range_valid)
      `CHK("unipolar", codes[k][2] && codes[k] != 4'h4, range_unipolar)
      apb(1, 12'(`REG_RANGE_BASE + 4 * (k % 8)), {28'h0, codes[9 - k]});
      model_range[k % 8] = codes[9 - k];
      `CHK("held", codes[k], active_range_code)
    end
    mask = 8'($random(seed)) | 8'h01;
    apb(1, `REG_SCAN_ENABLE, {24'h0, mask});
    apb(1, `REG_CTRL, 1);
    p = 1;
    if (!mask[p]) p = nxt(3'(p), mask);
    for (k = 0; k < 9; k++) begin
      frame_req <= 1'b1;
      @(posedge sys_clk);
      frame_req <= 1'b0;
      conv;
      `CHK("scan range", model_range[p], active_range_code)
      p = nxt(3'(p), mask);
      `CHK("scan ch", 3'(p), mux_channel)
    end
    i = 0;
    for (k = 0; k < 400; k++) begin
      frame_req <= (k == 0 || k == 100);
      @(posedge sys_clk);
      i += conv_start;
    end
    `CHK("rate", 1, i)
    reference_source_select <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK("buffer", 1'b1, internal_buffer_enable)
    reference_source_select <= 1'b0;
    repeat (6) @(posedge sys_clk);
    `CHK("ref out", 1'b1, reference_inout_pin_oe)
    stop_test;
  end
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
endmodule // tb_adc_range_scan_ctrl
